// ===== hdl/rsc_pkg.sv
// Purpose: shared constants and types for the reset source controller
// Assumes: 32-bit APB, one clock
// Notes: register offsets are byte addresses
package rsc_pkg;
  localparam logic [7:0] RSC_CTRL_ADDR = 8'h00;
  localparam logic [7:0] RSC_ENABLE_ADDR = 8'h04;
  localparam logic [7:0] RSC_MASK_ADDR = 8'h08;
  localparam logic [7:0] RSC_IRQ_ADDR = 8'h0c;
  localparam int RSC_WDT_BIT = 4;
  localparam int RSC_CM_BIT = 9;
  localparam int RSC_ILL_BIT = 14;
  localparam int RSC_TRAP_BIT = 15;
  localparam logic [15:0] RSC_FLAG_MASK = 16'hc210;
  localparam logic [15:0] RSC_CTRL_RST = 16'h0000;
  localparam logic [3:0] RSC_ENABLE_RST = 4'hf;
  localparam logic [3:0] RSC_MASK_RST = 4'h0;
  localparam logic [3:0] RSC_HARD_LO = 4'hd;
  localparam logic [3:0] RSC_HARD_HI = 4'hf;
  localparam logic [7:0] RSC_ILLEGAL_OP = 8'h3f;
  localparam int RSC_PPS_REGS = 4;
  localparam int RSC_PPS_W = 16;
  typedef struct packed {
    logic trap;
    logic ill;
    logic cm;
    logic wdt;
  } rsc_src_t;
endpackage

// ===== hdl/rsc_trap_check.sv
// Purpose: detects a lower priority hard trap arriving while a higher priority trap is processed
// Assumes: trap level is valid with trapReq
// Notes: priority 13..15 counts as hard
`timescale 1ns/1ns
module rsc_trap_check
  import rsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic trapReq,
  input wire logic [3:0] trapLevel,
  input wire logic trapDone,
  output logic conflict
);
  logic activeFf;
  logic [3:0] curLevelFf;
  logic nxtActive;
  logic [3:0] nxtCurLevel;
  logic isHard;
  always_comb begin
    isHard = (trapLevel >= RSC_HARD_LO) && (trapLevel <= RSC_HARD_HI); // R6
    conflict = trapReq && isHard && activeFf && (trapLevel < curLevelFf); // R5
    nxtActive = activeFf;
    nxtCurLevel = curLevelFf;
    if (trapDone) begin
      nxtActive = 1'b0;
    end
    if (trapReq && !activeFf) begin
      nxtActive = 1'b1;
      nxtCurLevel = trapLevel;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      activeFf <= 1'b0;
      curLevelFf <= 4'h0;
    end else begin
      activeFf <= nxtActive;
      curLevelFf <= nxtCurLevel;
    end
  end
endmodule

// ===== hdl/rsc_shadow_cmp.sv
// Purpose: keeps shadow copies of pin-select registers and flags mismatch
// Assumes: legal writes arrive on ppsWe with ppsIdx and ppsData
// Notes: a difference not caused by a legal write is a mismatch
`timescale 1ns/1ns
module rsc_shadow_cmp
  import rsc_pkg::*;
#(
  parameter int NREG = RSC_PPS_REGS,
  parameter int W = RSC_PPS_W
)(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ppsWe,
  input wire logic [$clog2(NREG)-1:0] ppsIdx,
  input wire logic [W-1:0] ppsData,
  input wire logic [NREG*W-1:0] ppsLive,
  output logic mismatch
);
  logic [W-1:0] shadowFf [NREG];
  logic [W-1:0] nxtShadow [NREG];
  always_comb begin
    mismatch = 1'b0;
    for (int i = 0; i < NREG; i++) begin
      nxtShadow[i] = shadowFf[i];
      if (ppsWe && (ppsIdx == i[$clog2(NREG)-1:0])) begin
        nxtShadow[i] = ppsData;
      end else if (ppsLive[i*W +: W] != shadowFf[i]) begin
        mismatch = 1'b1; // R8
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NREG; i++) begin
        shadowFf[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NREG; i++) begin
        shadowFf[i] <= nxtShadow[i];
      end
    end
  end
endmodule

// ===== hdl/rsc_reset_source_controller.sv
// Purpose: turns internal fault conditions into a system reset and records the cause
// Assumes: APB slave, sys_clk 250 MHz, flag register survives system_reset
// Notes: watchdog reset path is combinational from the timeout strobe
// Functional notes
// R1: watchdog expiry while running asserts system reset asynchronously, no clock edge needed.
// R2: watchdog reset leaves the clock source selection untouched.
// R3: watchdog expiry in sleep or idle wakes the processor, no reset.
// R4: watchdog timeout reset sets watchdog_timeout_flag, control register bit 4.
// R5: lower priority hard trap during higher priority trap causes trap conflict reset.
// R6: priority levels 13 to 15 are hard traps.
// R7: trap conflict reset sets trap_conflict_flag, bit 15.
// R8: pin-select registers compared to shadow copies; difference causes mismatch reset.
// R9: configuration mismatch reset sets config_mismatch_flag, bit 9.
// R10: illegal opcode, uninitialised working register or security violation cause reset.
// R11: any illegal condition reset sets illegal_condition_flag, bit 14.
// R12: executing a fetched illegal opcode generates a system reset.
// R13: software should fill upper byte of constant data words with 0x3f.
// R14: any enabled source asserts reset; flags stay set until software clears.
// R15: a reset sets only its own source flag.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
module rsc_reset_source_controller
  import rsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wdtExpire,
  input wire logic cpuSleep,
  input wire logic cpuIdle,
  input wire logic trapReq,
  input wire logic [3:0] trapLevel,
  input wire logic trapDone,
  input wire logic ppsWe,
  input wire logic [1:0] ppsIdx,
  input wire logic [15:0] ppsData,
  input wire logic [63:0] ppsLive,
  input wire logic fetchValid,
  input wire logic [23:0] fetchWord,
  input wire logic uninitWAccess,
  input wire logic securityViol,
  output logic system_reset,
  output logic clkSelHold,
  output logic cpuWake,
  output logic irq
);
  // combinational watchdog reset: the clock may be the fault, so no edge is awaited
  logic wdtRst;
  logic syncRstFf;
  logic nxtSyncRst;
  logic [15:0] ctrlFf;
  logic [15:0] nxtCtrl;
  logic [3:0] enableFf;
  logic [3:0] nxtEnable;
  logic [3:0] maskFf;
  logic [3:0] nxtMask;
  logic [3:0] irqStatFf;
  logic [3:0] nxtIrqStat;
  logic [31:0] prdataFf;
  logic [31:0] nxtPrdata;
  logic pslverrFf;
  logic nxtPslverr;
  logic wakeFf;
  logic nxtWake;
  logic irqFf;
  logic nxtIrq;
  logic wdtSeenFf;
  logic nxtWdtSeen;
  logic trapConflict;
  logic cfgMismatch;
  logic illegalOp;
  logic illegalCond;
  logic lowPower;
  logic wdtRun;
  rsc_src_t fire;
  logic apbWr;
  logic apbRd;
  logic apbSetup;
  logic [15:0] ctrlClr;

  rsc_trap_check u_trap (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .trapReq(trapReq),
    .trapLevel(trapLevel),
    .trapDone(trapDone),
    .conflict(trapConflict)
  );

  rsc_shadow_cmp #(.NREG(RSC_PPS_REGS), .W(RSC_PPS_W)) u_shadow (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ppsWe(ppsWe),
    .ppsIdx(ppsIdx),
    .ppsData(ppsData),
    .ppsLive(ppsLive),
    .mismatch(cfgMismatch)
  );

  function automatic logic sel_hit(input logic [7:0] a, input logic [7:0] r);
    sel_hit = (a == r);
  endfunction

  always_comb begin
    lowPower = cpuSleep || cpuIdle;
    wdtRun = wdtExpire && !lowPower;
    illegalOp = fetchValid && (fetchWord[23:16] == RSC_ILLEGAL_OP); // R12
    illegalCond = illegalOp || uninitWAccess || securityViol; // R10
    fire.wdt = wdtRun && enableFf[0];
    fire.cm = cfgMismatch && enableFf[1];
    fire.ill = illegalCond && enableFf[2];
    fire.trap = trapConflict && enableFf[3];
    wdtRst = fire.wdt; // R1
    apbWr = psel && penable && pwrite;
    apbRd = psel && penable && !pwrite;
    apbSetup = psel && !penable;
  end

  // R1 asynchronous watchdog term ORed with registered synchronous sources
  assign system_reset = wdtRst | syncRstFf; // R14
  // clock selection keeps its source across a watchdog reset
  assign clkSelHold = wdtRst | wdtSeenFf; // R2

  always_comb begin
    nxtSyncRst = fire.cm || fire.ill || fire.trap; // R14
    nxtWdtSeen = fire.wdt;
    nxtWake = wdtExpire && lowPower; // R3
    ctrlClr = 16'h0000;
    nxtEnable = enableFf;
    nxtMask = maskFf;
    nxtPslverr = 1'b0;
    nxtPrdata = prdataFf;
    nxtIrqStat = irqStatFf;
    if (apbWr) begin
      if (sel_hit(paddr, RSC_CTRL_ADDR)) begin
        ctrlClr = pwdata[15:0] & RSC_FLAG_MASK;
      end else if (sel_hit(paddr, RSC_ENABLE_ADDR)) begin
        nxtEnable = pwdata[3:0];
      end else if (sel_hit(paddr, RSC_MASK_ADDR)) begin
        nxtMask = pwdata[3:0];
      end else if (sel_hit(paddr, RSC_IRQ_ADDR)) begin
        nxtMask = maskFf;
      end
    end
    // decoded in the setup cycle, so data and error already stand when pready is sampled
    if (apbSetup) begin
      if (sel_hit(paddr, RSC_CTRL_ADDR)) begin
        nxtPrdata = {16'h0000, ctrlFf};
      end else if (sel_hit(paddr, RSC_ENABLE_ADDR)) begin
        nxtPrdata = {28'h0000000, enableFf};
      end else if (sel_hit(paddr, RSC_MASK_ADDR)) begin
        nxtPrdata = {28'h0000000, maskFf};
      end else if (sel_hit(paddr, RSC_IRQ_ADDR)) begin
        nxtPrdata = {28'h0000000, irqStatFf | fire};
      end else begin
        nxtPrdata = 32'h00000000;
        nxtPslverr = 1'b1;
      end
    end
    // read-clear lands at the access edge; a source firing in that cycle is kept
    if (apbRd && sel_hit(paddr, RSC_IRQ_ADDR)) begin
      nxtIrqStat = 4'h0;
    end
    // set wins over clear, a cause arriving during a clear is kept
    nxtCtrl = ctrlFf & ~ctrlClr; // R14
    nxtCtrl[RSC_WDT_BIT] = ctrlFf[RSC_WDT_BIT] & ~ctrlClr[RSC_WDT_BIT] | fire.wdt; // R4 R15
    nxtCtrl[RSC_CM_BIT] = ctrlFf[RSC_CM_BIT] & ~ctrlClr[RSC_CM_BIT] | fire.cm; // R9 R15
    nxtCtrl[RSC_ILL_BIT] = ctrlFf[RSC_ILL_BIT] & ~ctrlClr[RSC_ILL_BIT] | fire.ill; // R11 R15
    nxtCtrl[RSC_TRAP_BIT] = ctrlFf[RSC_TRAP_BIT] & ~ctrlClr[RSC_TRAP_BIT] | fire.trap; // R7 R15
    nxtIrqStat = nxtIrqStat | fire;
    // a set mask bit silences its source
    nxtIrq = |(nxtIrqStat & ~maskFf);
  end

  // flags and config are reset only by rst_b (power-on), not by system_reset,
  // so software can read the cause afterwards
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      syncRstFf <= 1'b0;
      wdtSeenFf <= 1'b0;
      wakeFf <= 1'b0;
      ctrlFf <= RSC_CTRL_RST;
      enableFf <= RSC_ENABLE_RST;
      maskFf <= RSC_MASK_RST;
      irqStatFf <= 4'h0;
      prdataFf <= 32'h00000000;
      pslverrFf <= 1'b0;
      irqFf <= 1'b0;
    end else begin
      syncRstFf <= nxtSyncRst;
      wdtSeenFf <= nxtWdtSeen;
      wakeFf <= nxtWake;
      ctrlFf <= nxtCtrl;
      enableFf <= nxtEnable;
      maskFf <= nxtMask;
      irqStatFf <= nxtIrqStat;
      prdataFf <= nxtPrdata;
      pslverrFf <= nxtPslverr;
      irqFf <= nxtIrq;
    end
  end

  assign prdata = prdataFf;
  assign pslverr = pslverrFf;
  assign pready = 1'b1;
  assign cpuWake = wakeFf;
  assign irq = irqFf;
endmodule

// ===== sim/rsc_checker_assertions.sv
// Purpose: port checks for the reset source controller
// Assumes: enable register keeps its reset value
// Notes: flags are only visible over the bus, so they are checked by the bench
`timescale 1ns/1ns
module rsc_checker
  import rsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wdtExpire,
  input wire logic cpuSleep,
  input wire logic cpuIdle,
  input wire logic trapReq,
  input wire logic [3:0] trapLevel,
  input wire logic trapDone,
  input wire logic ppsWe,
  input wire logic [63:0] ppsLive,
  input wire logic fetchValid,
  input wire logic [23:0] fetchWord,
  input wire logic uninitWAccess,
  input wire logic securityViol,
  input wire logic system_reset,
  input wire logic clkSelHold,
  input wire logic cpuWake
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire run = !cpuSleep && !cpuIdle;
  sequence trapTop;
    trapReq && trapLevel == 4'hf && !trapDone;
  endsequence
  sequence trapLow;
    trapReq && trapLevel == 4'hd && !trapDone;
  endsequence
  // submodule latency may add a cycle, hence the short range
  chk_trap_conflict: assert property (trapTop ##1 trapLow |-> ##[1:2] system_reset)
    else $error("trap conflict gave no reset");
  chk_wdt_async: assert property (wdtExpire && run |-> system_reset)
    else $error("watchdog reset missing");
  chk_clk_hold: assert property (wdtExpire && run |-> clkSelHold)
    else $error("clock select not held");
  chk_sleep_wake: assert property (wdtExpire && !run |=> cpuWake)
    else $error("no wake from low power");
  chk_illegal_op: assert property (fetchValid && fetchWord[23:16] == RSC_ILLEGAL_OP |=> system_reset)
    else $error("illegal opcode gave no reset");
  chk_uninit_reset: assert property (uninitWAccess |=> system_reset)
    else $error("uninit access gave no reset");
  chk_secure_reset: assert property (securityViol |=> system_reset)
    else $error("security fault gave no reset");
  chk_pps_change: assert property (!ppsWe && $changed(ppsLive) |-> ##[1:2] system_reset)
    else $error("pin select change gave no reset");
endmodule
bind rsc_reset_source_controller rsc_checker u_chk (.sys_clk, .rst_b, .wdtExpire, .cpuSleep, .cpuIdle,
  .trapReq, .trapLevel, .trapDone, .ppsWe, .ppsLive, .fetchValid, .fetchWord, .uninitWAccess,
  .securityViol, .system_reset, .clkSelHold, .cpuWake);

// ===== sim/rsc_reset_source_controller_tb_top.sv
// Purpose: directed bench for the reset source controller
// Assumes: read data and slave error stand at the edge that ends the access phase
// Notes: flags survive system_reset, so they accumulate across tests
`timescale 1ns/1ns
module rsc_reset_source_controller_tb_top
  import rsc_pkg::*;
;
  logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, er, system_reset, clkSelHold, cpuWake, irq;
  logic wdtExpire = 0, cpuSleep = 0, cpuIdle = 0, trapReq = 0, trapDone = 0, ppsWe = 0;
  logic [3:0] trapLevel = 0;
  logic [1:0] ppsIdx = 0;
  logic [15:0] ppsData = 0;
  logic [63:0] ppsLive = 0;
  logic fetchValid = 0, uninitWAccess = 0, securityViol = 0;
  logic [23:0] fetchWord = 0;
  int errors = 0, check_count = 0;
  always #2 sys_clk = ~sys_clk;
  rsc_reset_source_controller u_dut (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .wdtExpire, .cpuSleep, .cpuIdle, .trapReq, .trapLevel, .trapDone,
    .ppsWe, .ppsIdx, .ppsData, .ppsLive, .fetchValid, .fetchWord, .uninitWAccess, .securityViol,
    .system_reset, .clkSelHold, .cpuWake, .irq);
  task automatic complete_run(input bit t);
    if (t) errors++;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge sys_clk);
    end
    if (n == 50) complete_run(1);
    // answer taken at the same edge that samples pready, then the request is released
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rd, e);
  endtask
  task automatic trap(input logic [3:0] l);
    @(posedge sys_clk);
    trapReq <= 1;
    trapLevel <= l;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1;
    rdchk(RSC_CTRL_ADDR, 0);
    rdchk(RSC_ENABLE_ADDR, 32'h0000000f);
    apb(0, 8'h10, 0);
    chk(er, 1);
    $display("test regs done");
    @(posedge sys_clk);
    wdtExpire <= 1;
    #1 chk(system_reset, 1);
    chk(clkSelHold, 1);
    @(posedge sys_clk);
    wdtExpire <= 0;
    rdchk(RSC_CTRL_ADDR, 32'h10);
    chk(irq, 1);
    apb(1, RSC_MASK_ADDR, 32'hf);
    @(posedge sys_clk);
    #1 chk(irq, 0);
    apb(1, RSC_MASK_ADDR, 0);
    @(posedge sys_clk);
    #1 chk(irq, 1);
    rdchk(RSC_IRQ_ADDR, 32'h1);
    @(posedge sys_clk);
    #1 chk(irq, 0);
    apb(1, RSC_CTRL_ADDR, 32'h10);
    rdchk(RSC_CTRL_ADDR, 0);
    $display("test watchdog done");
    for (int m = 0; m < 2; m++) begin
      @(posedge sys_clk);
      cpuSleep <= (m == 0);
      cpuIdle <= (m == 1);
      wdtExpire <= 1;
      #1 chk(system_reset, 0);
      @(posedge sys_clk);
      wdtExpire <= 0;
      cpuSleep <= 0;
      cpuIdle <= 0;
      #1 chk(cpuWake, 1);
    end
    rdchk(RSC_CTRL_ADDR, 0);
    $display("test low power done");
    for (int s = 0; s < 3; s++) begin
      @(posedge sys_clk);
      fetchValid <= (s == 0);
      fetchWord <= {RSC_ILLEGAL_OP, 16'h1234};
      uninitWAccess <= (s == 1);
      securityViol <= (s == 2);
      @(posedge sys_clk);
      fetchValid <= 0;
      uninitWAccess <= 0;
      securityViol <= 0;
      #1 chk(system_reset, 1);
      rdchk(RSC_CTRL_ADDR, 32'h4000);
      apb(1, RSC_CTRL_ADDR, 32'h4000);
    end
    $display("test illegal done");
    trap(4'hf);
    trap(4'hc);
    @(posedge sys_clk);
    trapReq <= 0;
    trapDone <= 1;
    repeat (2) @(posedge sys_clk);
    trapDone <= 0;
    rdchk(RSC_CTRL_ADDR, 0);
    trap(4'hf);
    trap(4'hd);
    @(posedge sys_clk);
    trapReq <= 0;
    rdchk(RSC_CTRL_ADDR, 32'h8000);
    $display("test trap done");
    @(posedge sys_clk);
    ppsWe <= 1;
    ppsIdx <= 2'd1;
    ppsData <= 16'h00a5;
    ppsLive[31:16] <= 16'h00a5;
    @(posedge sys_clk);
    ppsWe <= 0;
    rdchk(RSC_CTRL_ADDR, 32'h8000);
    @(posedge sys_clk);
    ppsLive[31:16] <= 16'h00a4;
    @(posedge sys_clk);
    ppsWe <= 1;
    ppsData <= 16'h00a4;
    @(posedge sys_clk);
    ppsWe <= 0;
    rdchk(RSC_CTRL_ADDR, 32'h8200);
    apb(1, RSC_CTRL_ADDR, 32'hc210);
    rdchk(RSC_CTRL_ADDR, 0);
    $display("test mismatch done");
    complete_run(0);
  end
endmodule
